// >>> pci_primary_addr_data_parity.sv
`timescale 1ns/1ns
`include "pci_pri_regs.svh"

module pci_primary_addr_data_parity #(
    parameter int BUS_MHZ = 66,
    parameter bit SLOW_VARIANT = 1'b0
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic [31:0] ad_in,
    output logic [31:0] ad_out,
    output logic ad_oe_out,
    input wire logic [3:0] primary_cmd_byte_en_in,
    output logic [3:0] primary_cmd_byte_en_out,
    output logic primary_cmd_byte_en_oe_out,
    input wire logic primary_parity_bit_in,
    output logic primary_parity_bit_out,
    output logic primary_parity_bit_oe_out,
    input wire logic frame_n_in,
    output logic frame_n_out,
    output logic frame_oe_out,
    input wire logic primary_initiator_ready_n_in,
    output logic primary_initiator_ready_n_out,
    output logic primary_initiator_ready_n_oe_out,
    input wire logic primary_target_ready_n_in,
    output logic primary_target_ready_n_out,
    output logic primary_target_ready_n_oe_out,
    input wire logic grant_n_in,
    input wire logic mst_start_in,
    input wire logic mst_write_in,
    input wire logic [31:0] mst_addr_in,
    input wire logic [3:0] mst_cmd_in,
    input wire logic [31:0] mst_wdata_in,
    input wire logic [3:0] mst_byte_en_in,
    output logic mst_busy_out,
    output logic mst_done_out,
    output logic [31:0] mst_rdata_out,
    input wire logic tgt_read_in,
    input wire logic [31:0] tgt_rdata_in,
    output logic tgt_done_out,
    output logic addr_par_err_out,
    output logic data_par_err_out
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    // clock ceiling
    if (BUS_MHZ < 1 || BUS_MHZ > (SLOW_VARIANT ? `PRI_MAX_MHZ_SLOW : `PRI_MAX_MHZ)) begin : g_chk
        $error("bus clock rate out of range for this variant");
    end

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    pci_pri_pkg::pin_sample_t pin_raw;
    pci_pri_pkg::pin_sample_t sync1_q;
    pci_pri_pkg::pin_sample_t pin_q;
    pci_pri_pkg::pin_sample_t pin_prev_q;

    assign pin_raw = '{ad: ad_in, cbe: primary_cmd_byte_en_in, par: primary_parity_bit_in,
                       frame_n: frame_n_in, irdy_n: primary_initiator_ready_n_in,
                       trdy_n: primary_target_ready_n_in, gnt_n: grant_n_in};

    // two stages before use; idle-high reset keeps strobes deasserted
    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            sync1_q <= '{ad: 32'h0, cbe: 4'h0, par: 1'b0, frame_n: 1'b1, irdy_n: 1'b1,
                         trdy_n: 1'b1, gnt_n: 1'b1};
            pin_q <= '{ad: 32'h0, cbe: 4'h0, par: 1'b0, frame_n: 1'b1, irdy_n: 1'b1,
                       trdy_n: 1'b1, gnt_n: 1'b1};
            pin_prev_q <= '{ad: 32'h0, cbe: 4'h0, par: 1'b0, frame_n: 1'b1, irdy_n: 1'b1,
                            trdy_n: 1'b1, gnt_n: 1'b1};
        end else begin
            sync1_q <= pin_raw;
            pin_q <= sync1_q;
            pin_prev_q <= pin_q;
        end
    end

    // ------------------------------------------------------------
    // transaction state and pin drive
    // ------------------------------------------------------------
    pci_pri_pkg::mst_state_t mst_q, mst_d;
    pci_pri_pkg::tgt_state_t tgt_q, tgt_d;
    pci_pri_pkg::ad_cbe_t drv_q, drv_d;
    logic ad_oe_q, ad_oe_d, cbe_oe_q, cbe_oe_d;
    logic frame_n_q, frame_n_d, frame_oe_q, frame_oe_d;
    logic irdy_n_q, irdy_n_d, irdy_oe_q, irdy_oe_d;
    logic trdy_n_q, trdy_n_d, trdy_oe_q, trdy_oe_d;
    logic write_q, write_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0] be_q, be_d;
    logic mst_done_q, mst_done_d, tgt_done_q, tgt_done_d;
    logic bus_idle;

    assign bus_idle = pin_q.frame_n && pin_q.irdy_n;

    always_comb begin
        mst_d = mst_q;
        tgt_d = tgt_q;
        drv_d = drv_q;
        ad_oe_d = 1'b0;
        cbe_oe_d = 1'b0;
        frame_n_d = 1'b1;
        frame_oe_d = 1'b0;
        irdy_n_d = 1'b1;
        irdy_oe_d = 1'b0;
        trdy_n_d = 1'b1;
        trdy_oe_d = 1'b0;
        write_d = write_q;
        wdata_d = wdata_q;
        be_d = be_q;
        rdata_d = rdata_q;
        mst_done_d = 1'b0;
        tgt_done_d = 1'b0;
        case (mst_q)
            pci_pri_pkg::MST_IDLE: begin
                if (mst_start_in && !pin_q.gnt_n && bus_idle &&
                    tgt_q == pci_pri_pkg::TGT_IDLE) begin
                    mst_d = pci_pri_pkg::MST_ADDR;
                    drv_d = '{ad: mst_addr_in, cbe: mst_cmd_in};
                    write_d = mst_write_in;
                    wdata_d = mst_wdata_in;
                    be_d = mst_byte_en_in;
                    ad_oe_d = 1'b1;
                    cbe_oe_d = 1'b1;
                    frame_n_d = 1'b0;
                    frame_oe_d = 1'b1;
                end
            end
            pci_pri_pkg::MST_ADDR: begin
                // byte enables replace command; single final phase
                mst_d = pci_pri_pkg::MST_DATA;
                drv_d = '{ad: write_q ? wdata_q : drv_q.ad, cbe: be_q};
                ad_oe_d = write_q;
                cbe_oe_d = 1'b1;
                frame_oe_d = 1'b1;
                irdy_n_d = 1'b0;
                irdy_oe_d = 1'b1;
            end
            pci_pri_pkg::MST_DATA: begin
                cbe_oe_d = 1'b1;
                ad_oe_d = write_q;
                // word moves only with target ready sampled low
                if (!pin_q.trdy_n) begin
                    mst_d = pci_pri_pkg::MST_REL;
                    rdata_d = pin_q.ad;
                    mst_done_d = 1'b1;
                    ad_oe_d = 1'b0;
                    cbe_oe_d = 1'b0;
                    irdy_oe_d = 1'b1;
                end else begin
                    irdy_n_d = 1'b0;
                    irdy_oe_d = 1'b1;
                end
            end
            pci_pri_pkg::MST_REL: begin
                mst_d = pci_pri_pkg::MST_IDLE;
            end
            default: mst_d = pci_pri_pkg::MST_IDLE;
        endcase
        case (tgt_q)
            pci_pri_pkg::TGT_IDLE: begin
                // wait for initiator ready in the synced view, so the byte enables that
                // read parity must cover are already known when target ready goes low
                if (tgt_read_in && mst_q == pci_pri_pkg::MST_IDLE && !mst_start_in &&
                    !pin_q.irdy_n) begin
                    tgt_d = pci_pri_pkg::TGT_DATA;
                    drv_d.ad = tgt_rdata_in;
                    ad_oe_d = 1'b1;
                    trdy_n_d = 1'b0;
                    trdy_oe_d = 1'b1;
                end
            end
            pci_pri_pkg::TGT_DATA: begin
                // completes only with initiator ready sampled low
                if (!pin_q.irdy_n) begin
                    tgt_d = pci_pri_pkg::TGT_REL;
                    tgt_done_d = 1'b1;
                    // target ready driven high one clock
                    trdy_oe_d = 1'b1;
                end else begin
                    ad_oe_d = 1'b1;
                    trdy_n_d = 1'b0;
                    trdy_oe_d = 1'b1;
                end
            end
            pci_pri_pkg::TGT_REL: tgt_d = pci_pri_pkg::TGT_IDLE;
            default: tgt_d = pci_pri_pkg::TGT_IDLE;
        endcase
        // park lanes while idle and granted
        if (mst_d == pci_pri_pkg::MST_IDLE && tgt_d == pci_pri_pkg::TGT_IDLE &&
            mst_q == pci_pri_pkg::MST_IDLE && tgt_q == pci_pri_pkg::TGT_IDLE &&
            !pin_q.gnt_n && bus_idle) begin
            drv_d = '{ad: `PRI_PARK_AD, cbe: `PRI_PARK_CBE};
            ad_oe_d = 1'b1;
            cbe_oe_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            mst_q <= pci_pri_pkg::MST_IDLE;
            tgt_q <= pci_pri_pkg::TGT_IDLE;
            drv_q <= '{ad: 32'h0, cbe: 4'h0};
            ad_oe_q <= 1'b0;
            cbe_oe_q <= 1'b0;
            frame_n_q <= 1'b1;
            frame_oe_q <= 1'b0;
            irdy_n_q <= 1'b1;
            irdy_oe_q <= 1'b0;
            trdy_n_q <= 1'b1;
            trdy_oe_q <= 1'b0;
            write_q <= 1'b0;
            wdata_q <= 32'h0;
            be_q <= 4'h0;
            rdata_q <= 32'h0;
            mst_done_q <= 1'b0;
            tgt_done_q <= 1'b0;
        end else begin
            mst_q <= mst_d;
            tgt_q <= tgt_d;
            drv_q <= drv_d;
            ad_oe_q <= ad_oe_d;
            cbe_oe_q <= cbe_oe_d;
            frame_n_q <= frame_n_d;
            frame_oe_q <= frame_oe_d;
            irdy_n_q <= irdy_n_d;
            irdy_oe_q <= irdy_oe_d;
            trdy_n_q <= trdy_n_d;
            trdy_oe_q <= trdy_oe_d;
            write_q <= write_d;
            wdata_q <= wdata_d;
            be_q <= be_d;
            rdata_q <= rdata_d;
            mst_done_q <= mst_done_d;
            tgt_done_q <= tgt_done_d;
        end
    end

    // ------------------------------------------------------------
    // parity generation and checking
    // ------------------------------------------------------------
    logic par_q, par_d, par_oe_q, par_oe_d;
    logic exp_par_q, exp_par_d, chk_addr_q, chk_addr_d, chk_data_q, chk_data_d;
    logic addr_err_q, addr_err_d, data_err_q, data_err_d;
    pci_pri_pkg::ad_cbe_t par_src;

    always_comb begin
        // parity of last clock's lanes; as target the command lanes are
        // the initiator's, taken from the synced view, which it holds for the phase
        par_src = '{ad: drv_q.ad, cbe: cbe_oe_q ? drv_q.cbe : pin_q.cbe};
        par_d = ^par_src;
        // parity follows the lanes by one clock
        par_oe_d = ad_oe_q;
        // expected parity of sampled lanes, compared a clock later
        exp_par_d = ^{pin_q.ad, pin_q.cbe};
        // address phase driven by someone else
        chk_addr_d = !pin_q.frame_n && pin_prev_q.frame_n && !frame_oe_q;
        // word driven by the far side: read data we initiated (the target path serves reads only)
        chk_data_d = !pin_q.irdy_n && !pin_q.trdy_n && !ad_oe_q;
        addr_err_d = chk_addr_q && (pin_q.par != exp_par_q);
        data_err_d = chk_data_q && (pin_q.par != exp_par_q);
    end

    always_ff @(posedge sys_clk_in) begin
        if (!nrst_in) begin
            par_q <= 1'b0;
            par_oe_q <= 1'b0;
            exp_par_q <= 1'b0;
            chk_addr_q <= 1'b0;
            chk_data_q <= 1'b0;
            addr_err_q <= 1'b0;
            data_err_q <= 1'b0;
        end else begin
            par_q <= par_d;
            par_oe_q <= par_oe_d;
            exp_par_q <= exp_par_d;
            chk_addr_q <= chk_addr_d;
            chk_data_q <= chk_data_d;
            addr_err_q <= addr_err_d;
            data_err_q <= data_err_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign ad_out = drv_q.ad;
    assign ad_oe_out = ad_oe_q;
    assign primary_cmd_byte_en_out = drv_q.cbe;
    assign primary_cmd_byte_en_oe_out = cbe_oe_q;
    assign primary_parity_bit_out = par_q;
    assign primary_parity_bit_oe_out = par_oe_q;
    assign frame_n_out = frame_n_q;
    assign frame_oe_out = frame_oe_q;
    assign primary_initiator_ready_n_out = irdy_n_q;
    assign primary_initiator_ready_n_oe_out = irdy_oe_q;
    assign primary_target_ready_n_out = trdy_n_q;
    assign primary_target_ready_n_oe_out = trdy_oe_q;
    assign mst_busy_out = (mst_q != pci_pri_pkg::MST_IDLE);
    assign mst_done_out = mst_done_q;
    assign mst_rdata_out = rdata_q;
    assign tgt_done_out = tgt_done_q;
    assign addr_par_err_out = addr_err_q;
    assign data_par_err_out = data_err_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);

    a_irdy_release_high: assert property ($fell(irdy_oe_q) |-> $past(irdy_n_q))
        else $error("initiator ready floated without a high cycle");
    a_frame_release_high: assert property ($fell(frame_oe_q) |-> $past(frame_n_q))
        else $error("frame floated without a high cycle");
    a_addr_on_frame: assert property ($fell(frame_n_q) |-> ad_oe_q ##1 frame_n_q)
        else $error("address phase without driven lanes");
    a_be_after_cmd: assert property ($fell(frame_n_q) |=> drv_q.cbe == be_q && cbe_oe_q)
        else $error("byte enables not driven after command");
    a_rd_data_stable: assert property (!trdy_n_q && $past(!trdy_n_q) |-> $stable(drv_q.ad))
        else $error("read data moved while target ready");
    a_xfer_both_ready: assert property (mst_done_q |->
        !$past(pin_q.trdy_n) && !$past(irdy_n_q))
        else $error("word completed without both ready strobes");
    a_irdy_held: assert property (!irdy_n_q && pin_q.trdy_n
        && mst_q == pci_pri_pkg::MST_DATA |=> !irdy_n_q)
        else $error("initiator ready dropped before completion");
    a_par_lags_lanes: assert property (par_oe_q == $past(ad_oe_q))
        else $error("parity enable does not lag lanes by one clock");
    a_par_even: assert property (par_oe_q |-> ^{par_q, $past(par_src)} == 1'b0)
        else $error("driven parity is odd");
    a_park_drives: assert property (mst_q == pci_pri_pkg::MST_IDLE
        && tgt_q == pci_pri_pkg::TGT_IDLE && !pin_q.gnt_n && bus_idle
        && !mst_start_in && !tgt_read_in |=> ad_oe_q ##1 par_oe_q)
        else $error("granted idle bus not parked");

endmodule

// >>> pci_pri_regs.svh
`ifndef PCI_PRI_REGS_SVH
`define PCI_PRI_REGS_SVH

// bus geometry
`define PRI_AD_W 32
`define PRI_CBE_W 4

// highest bus clock the path serves, full and reduced-speed variants
`define PRI_MAX_MHZ 66
`define PRI_MAX_MHZ_SLOW 33

// value driven while parking on the bus
`define PRI_PARK_AD 32'h0000_0000
`define PRI_PARK_CBE 4'h0

`endif

// >>> pci_pri_pkg.sv
package pci_pri_pkg;

    // one sample of the primary bus pins
    typedef struct packed {
        logic [31:0] ad;
        logic [3:0] cbe;
        logic par;
        logic frame_n;
        logic irdy_n;
        logic trdy_n;
        logic gnt_n;
    } pin_sample_t;

    // address/data and command/byte-enable lanes as one word
    typedef struct packed {
        logic [31:0] ad;
        logic [3:0] cbe;
    } ad_cbe_t;

    typedef enum logic [1:0] {MST_IDLE, MST_ADDR, MST_DATA, MST_REL} mst_state_t;
    typedef enum logic [1:0] {TGT_IDLE, TGT_DATA, TGT_REL} tgt_state_t;

endpackage

// >>> pci_pri_agent.sv
`timescale 1ns/1ns

// ----------------------------------------
// far-side bus agent
// ----------------------------------------
// target for bridge cycles, initiator of reads from the bridge; behavioural,
// so one clocked block holds all of its state
module pci_pri_agent (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire pci_pri_pkg::pin_sample_t bus_in,
    input wire logic go_in,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] rdata_in,
    input wire logic [3:0] be_in,
    input wire logic [1:0] wait_in,
    input wire logic bad_par_in,
    output pci_pri_pkg::pin_sample_t drv_out,
    output logic [5:0] oe_out,
    output pci_pri_pkg::ad_cbe_t acap_out,
    output pci_pri_pkg::ad_cbe_t dcap_out,
    output logic cap_par_out
);
    // oe_out bits: ad, cbe, par, frame, irdy, trdy
    localparam logic [2:0] IDLE = 3'h0, T_WAIT = 3'h1, T_XFER = 3'h2, T_REL = 3'h3;
    localparam logic [2:0] I_DATA = 3'h4, I_WAIT = 3'h5, I_PAR = 3'h6;
    logic [2:0] st;
    logic [1:0] cnt;
    logic rd;

    // one step of the agent per clock
    always @(posedge clk_in) begin
        if (!nrst_in) begin
            st <= IDLE;
            oe_out <= 6'h00;
            drv_out <= {41{1'h1}};
        end else begin
            case (st)
                IDLE: begin
                    if (go_in) begin
                        drv_out.frame_n <= 1'b0;
                        drv_out.ad <= addr_in;
                        drv_out.cbe <= 4'h6;
                        oe_out <= 6'h34;
                        st <= I_DATA;
                    end else if (!bus_in.frame_n) begin
                        acap_out <= {bus_in.ad, bus_in.cbe};
                        rd <= !bus_in.cbe[0];
                        cnt <= wait_in;
                        st <= T_WAIT;
                    end
                end
                // read word stable with target ready
                T_WAIT: begin
                    if (cnt == 2'h0) begin
                        drv_out.trdy_n <= 1'b0;
                        drv_out.ad <= rdata_in;
                        oe_out <= {rd, 4'h0, 1'b1};
                        st <= T_XFER;
                    end
                    cnt <= cnt - 2'h1;
                end
                T_XFER: begin
                    drv_out.par <= ^{drv_out.ad, bus_in.cbe} ^ bad_par_in;
                    oe_out[3] <= rd;
                    if (!bus_in.irdy_n) begin
                        dcap_out <= {bus_in.ad, bus_in.cbe};
                        drv_out.trdy_n <= 1'b1;
                        oe_out[5] <= 1'b0;
                        st <= T_REL;
                    end
                end
                T_REL: begin
                    oe_out <= 6'h00;
                    st <= IDLE;
                end
                I_DATA: begin
                    drv_out.frame_n <= 1'b1;
                    drv_out.irdy_n <= 1'b0;
                    drv_out.cbe <= be_in;
                    drv_out.par <= ^{drv_out.ad, drv_out.cbe} ^ bad_par_in;
                    oe_out <= 6'h1e;
                    st <= I_WAIT;
                end
                I_WAIT: begin
                    oe_out[3] <= 1'b0;
                    if (!bus_in.trdy_n) begin
                        dcap_out <= {bus_in.ad, bus_in.cbe};
                        drv_out.irdy_n <= 1'b1;
                        st <= I_PAR;
                    end
                end
                default: begin
                    cap_par_out <= bus_in.par;
                    oe_out <= 6'h00;
                    st <= IDLE;
                end
            endcase
        end
    end
endmodule

// >>> tb_top.sv
`timescale 1ns/1ns

module tb_top;
    logic clk = 1'b0, nrst = 1'b0, gnt_n = 1'b0;
    logic mst_start, mst_write, tgt_read, go, a_bad;
    logic [31:0] mst_addr, mst_wdata, tgt_rdata, a_addr, a_rdata, mst_rdata, d_ad;
    logic [3:0] mst_cmd, mst_be, a_be, d_cbe;
    logic [1:0] a_wait;
    logic d_ad_oe, d_cbe_oe, d_par, d_par_oe, d_fr, d_fr_oe, d_ir, d_ir_oe, d_tr, d_tr_oe;
    logic busy, done, tdone, ape, dpe, cap_par, p_ad_oe = 1'b0, p2_ad_oe = 1'b0;
    logic p_fr = 1'b1, p_fr_oe = 1'b0, p_ir = 1'b1, p_ir_oe = 1'b0, p_tr = 1'b1, p_tr_oe = 1'b0;
    logic [5:0] aoe;
    pci_pri_pkg::pin_sample_t w, agt, last = {41{1'h0}};
    pci_pri_pkg::ad_cbe_t acap, dcap, p_w;
    int miscompares = 0, samples_checked = 0, ape_n = 0, dpe_n = 0, exp_ape = 0, exp_dpe = 0;

    // ----------------------------------------
    // clock, bus wires, parties
    // ----------------------------------------
    always #25 clk = ~clk;

    // released lanes show the inverse of their last level, strobes pull high
    always_comb begin
        w.ad = d_ad_oe ? d_ad : (aoe[5] ? agt.ad : ~last.ad);
        w.cbe = d_cbe_oe ? d_cbe : (aoe[4] ? agt.cbe : ~last.cbe);
        w.par = d_par_oe ? d_par : (aoe[3] ? agt.par : ~last.par);
        w.frame_n = d_fr_oe ? d_fr : (aoe[2] ? agt.frame_n : 1'b1);
        w.irdy_n = d_ir_oe ? d_ir : (aoe[1] ? agt.irdy_n : 1'b1);
        w.trdy_n = d_tr_oe ? d_tr : (aoe[0] ? agt.trdy_n : 1'b1);
        w.gnt_n = gnt_n;
    end
    always @(posedge clk) last <= w;

    pci_primary_addr_data_parity dut_u (
        .sys_clk_in(clk), .nrst_in(nrst), .ad_in(w.ad), .ad_out(d_ad), .ad_oe_out(d_ad_oe),
        .primary_cmd_byte_en_in(w.cbe), .primary_cmd_byte_en_out(d_cbe),
        .primary_cmd_byte_en_oe_out(d_cbe_oe), .primary_parity_bit_in(w.par),
        .primary_parity_bit_out(d_par), .primary_parity_bit_oe_out(d_par_oe),
        .frame_n_in(w.frame_n), .frame_n_out(d_fr), .frame_oe_out(d_fr_oe),
        .primary_initiator_ready_n_in(w.irdy_n), .primary_initiator_ready_n_out(d_ir),
        .primary_initiator_ready_n_oe_out(d_ir_oe), .primary_target_ready_n_in(w.trdy_n),
        .primary_target_ready_n_out(d_tr), .primary_target_ready_n_oe_out(d_tr_oe),
        .grant_n_in(gnt_n), .mst_start_in(mst_start), .mst_write_in(mst_write),
        .mst_addr_in(mst_addr), .mst_cmd_in(mst_cmd), .mst_wdata_in(mst_wdata),
        .mst_byte_en_in(mst_be), .mst_busy_out(busy), .mst_done_out(done),
        .mst_rdata_out(mst_rdata), .tgt_read_in(tgt_read), .tgt_rdata_in(tgt_rdata),
        .tgt_done_out(tdone), .addr_par_err_out(ape), .data_par_err_out(dpe));

    pci_pri_agent agent_u (
        .clk_in(clk), .nrst_in(nrst), .bus_in(w), .go_in(go), .addr_in(a_addr),
        .rdata_in(a_rdata), .be_in(a_be), .wait_in(a_wait), .bad_par_in(a_bad),
        .drv_out(agt), .oe_out(aoe), .acap_out(acap), .dcap_out(dcap), .cap_par_out(cap_par));

    // ----------------------------------------
    // compare and closing helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic par_of(input pci_pri_pkg::ad_cbe_t v);
        return ^v;
    endfunction

    task automatic end_of_test;
        if (miscompares == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic tick;
        @(posedge clk);
        #5;
    endtask

    // watch the pins every clock: parity, release order, contention
    always @(posedge clk) if (nrst) begin
        ape_n += int'(ape);
        dpe_n += int'(dpe);
        if (p_ad_oe && d_par_oe) check("parity", d_par, par_of(p_w));
        if (p_ad_oe && !d_ad_oe) check("par held", d_par_oe, 1'b1);
        if (p2_ad_oe && !p_ad_oe && !d_ad_oe) check("par freed", d_par_oe, 1'b0);
        if (p_fr_oe && !d_fr_oe) check("frame release", p_fr, 1'b1);
        if (p_ir_oe && !d_ir_oe) check("irdy release", p_ir, 1'b1);
        if (p_tr_oe && !d_tr_oe) check("trdy release", p_tr, 1'b1);
        check("clash", {d_ad_oe & aoe[5], d_par_oe & aoe[3], d_tr_oe & aoe[0]}, 3'h0);
        {p2_ad_oe, p_ad_oe, p_w} = {p_ad_oe, d_ad_oe, w.ad, w.cbe};
        {p_fr, p_fr_oe, p_ir, p_ir_oe} = {d_fr, d_fr_oe, d_ir, d_ir_oe};
        {p_tr, p_tr_oe} = {d_tr, d_tr_oe};
    end

    // ----------------------------------------
    // transactions
    // ----------------------------------------
    task automatic mst(input logic wr, input logic [1:0] wt, input logic bad);
        logic [31:0] a, d, rd;
        logic [3:0] be, cmd;
        int n;
        a = $urandom;
        d = $urandom;
        rd = $urandom;
        be = 4'($urandom);
        cmd = {1'b0, 1'($urandom), 1'b1, wr};
        {mst_addr, mst_cmd, mst_wdata, mst_be, mst_write} = {a, cmd, d, be, wr};
        {a_rdata, a_wait, a_bad, mst_start} = {rd, wt, bad & !wr, 1'b1};
        n = 0;
        do begin tick; n++; end while (busy !== 1'b1 && n < 20);
        mst_start = 1'b0;
        while (done !== 1'b1 && n < 60) begin tick; n++; end
        check("mst done", done, 1'b1);
        check("addr phase", acap, {a, cmd});
        if (wr) check("write word", dcap, {d, be});
        else check("read word", mst_rdata, rd);
        exp_dpe += int'(bad & !wr);
        repeat (4) tick;
        check("data par err", dpe_n, exp_dpe);
        while (busy !== 1'b0 && n < 80) begin tick; n++; end
    endtask

    task automatic tgt(input logic bad);
        logic [31:0] a, d;
        logic [3:0] be;
        int n;
        a = $urandom;
        d = $urandom;
        be = 4'($urandom);
        // serve request stands until the bridge answers with target ready
        {a_addr, a_be, a_bad, tgt_rdata, go, tgt_read} = {a, be, bad, d, 2'h3};
        tick;
        go = 1'b0;
        n = 0;
        while (d_tr_oe !== 1'b1 && n < 20) begin tick; n++; end
        tgt_read = 1'b0;
        while (tdone !== 1'b1 && n < 40) begin tick; n++; end
        check("tgt done", tdone, 1'b1);
        exp_ape += int'(bad);
        repeat (4) tick;
        check("tgt word", dcap, {d, be});
        check("tgt parity", cap_par, par_of({d, be}));
        check("addr par err", ape_n, exp_ape);
    endtask

    // one pass through the bus run is a few hundred clocks; allow far more
    initial begin
        #500000;
        miscompares++;
        end_of_test;
    end

    initial begin
        {mst_start, mst_write, tgt_read, go, a_bad, a_wait} = 7'h00;
        {mst_addr, mst_wdata, tgt_rdata, a_addr, a_rdata} = {160{1'h0}};
        {mst_cmd, mst_be, a_be} = 12'h000;
        void'($urandom(11903));
        repeat (8) tick;
        nrst = 1'b1;
        repeat (6) tick;
        check("park", {d_ad_oe, d_cbe_oe, d_par_oe, d_ad, d_cbe, d_par}, 40'he0_0000_0000);
        // corners: prompt write, slowest read, bad read parity, back to back
        mst(1'b1, 2'h0, 1'b0);
        mst(1'b0, 2'h3, 1'b0);
        mst(1'b0, 2'h0, 1'b1);
        for (int i = 0; i < 16; i++) mst(1'($urandom), 2'($urandom), ($urandom % 4) == 0);
        gnt_n = 1'b1;
        repeat (6) tick;
        tgt(1'b0);
        tgt(1'b1);
        for (int i = 0; i < 4; i++) tgt(1'($urandom));
        gnt_n = 1'b0;
        repeat (6) tick;
        check("repark", {d_ad_oe, d_cbe_oe, d_par_oe, d_ad, d_cbe}, 39'h70_0000_0000);
        end_of_test;
    end
endmodule
